// [pll_consts.svh]
// constants for the divider and lock detect block
// assumes a single 40 MHz system clock and word-wide serial registers
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH
// register addresses on the serial port
`define PLL_ADDR_RDIV 6'h02
`define PLL_ADDR_NINT 6'h03
`define PLL_ADDR_NFRAC 6'h04
`define PLL_ADDR_MODCFG 6'h06
`define PLL_ADDR_LDCFG 6'h07
`define PLL_ADDR_PDCTL 6'h0B
`define PLL_ADDR_OUTCFG 6'h0F
`define PLL_ADDR_STATUS 6'h12
// field positions
`define PLL_DETECTOR_RAISE_ENABLE 5
`define PLL_DETECTOR_LOWER_ENABLE 6
`define PLL_PUMP_FORCE_RAISE 9
`define PLL_PUMP_FORCE_LOWER 10
`define PLL_LD_ENABLE 3
`define PLL_LD_WINSEL 6
`define PLL_MOD_ENABLE 11
`define PLL_MOD_BYPASS 7
`define PLL_OUT_KEEP 6
`define PLL_STAT_LOCK 1
`define PLL_STAT_OPEN 0
// reset values
`define PLL_RST_RDIV 14'h0001
`define PLL_RST_NINT 19'h00014
`define PLL_RST_ZERO 24'h000000
// divider ranges
`define PLL_N_MIN_INT 19'h00010
`define PLL_N_MIN_FRAC 19'h00014
`define PLL_N_MAX_FRAC 19'h7FFFB
`define PLL_OUT_SEL_LOCK 5'h01
// timing
`define PLL_CLOCK_MHZ 40
`define PLL_CLOCK_PERIOD_NS (1000 / `PLL_CLOCK_MHZ)
`define PLL_ANALOG_WIN_NS 10
`define PLL_ANALOG_WIN_CYC \
    (((`PLL_ANALOG_WIN_NS / `PLL_CLOCK_PERIOD_NS) < 1) ? 1 : \
    (`PLL_ANALOG_WIN_NS / `PLL_CLOCK_PERIOD_NS))
`define PLL_LOCK_SHIFT 4
`define PLL_FRAME_ADDR_LAST 5'h06
`define PLL_FRAME_LAST 5'h1E
`endif

// [pll_pkg.sv]
// types shared by the divider and lock detect block
// assumes pll_consts.svh provides all numeric constants
package pll_pkg;
    // serial port frame sequencer
    typedef enum logic [1:0] {
        pll_ser_idle,
        pll_ser_addr,
        pll_ser_data,
        pll_ser_wait
    } pll_ser_state_type;
    // lock detector window clock count
    typedef logic [10:0] pll_window_type;
endpackage : pll_pkg

// [pll_div_counter.sv]
// edge counting integer divider, one output pulse per ratio input edges
// assumes edge_in is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module pll_div_counter #(
    parameter int WIDTH = 14
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic edge_in,
    input wire logic [WIDTH-1:0] ratio,
    output logic pulse
);
    // edges seen since the last output pulse
    logic [WIDTH-1:0] count;

    // count edges; a ratio of zero behaves as one
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            pulse <= 1'b0;
        end
        else
        begin
            pulse <= 1'b0;
            if (edge_in)
            begin
                if (ratio == '0 || count >= ratio - 1'b1)
                begin
                    count <= '0;
                    pulse <= 1'b1;
                end
                else
                begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule : pll_div_counter

// [pll_lock_detect.sv]
// reference and rf dividers, phase detector gating and window lock detect
// assumes ref_in and vco_in edges are slower than a quarter of the clock,
// and a serial host framing writes with serial_enable high
//
// Notes on behaviour
// - reference divider 14 bits, ratio 1 to 16383
// - rf divider fractional 20..524283, integer 16..524287
// - up enable low masks pump up
// - down enable low masks pump down
// - both enables and both force bits low tri-states charge pump
// - force bits drive pump up or down
// - global enable gates all lock detection
// - measure arrival gap, either edge first
// - window select low gives a one-cycle window, the 10 ns rounded up to one clock
// - window select high uses timer cycles
// - divide codes give 1 to 64 cycles, code 0 rounded up from 0.5
// - speed field slows timer clock, longer window
// - count field sets consecutive hits for lock
// - one miss clears lock immediately
// - lock flag readable at status bit 1
// - select one drives lock on shared pin
// - shared pin shows serial data during reads unless keep bit 6 is set
// - window opens on first arriving edge
// - integer mode uses integer divide register
// - fractional when enable set, bypass clear
`timescale 1ns/1ps
`include "pll_consts.svh"
module pll_lock_detect
    import pll_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ref_in,
    input wire logic vco_in,
    input wire logic serial_clock,
    input wire logic serial_enable,
    input wire logic serial_in,
    output logic pump_raise,
    output logic pump_lower,
    output logic pump_hiz,
    output logic lock_or_serial_out_pin
);
    // two-stage synchronisers, plus an edge delay stage on ref, vco and serial clock only
    logic [2:0] ref_sync, vco_sync, sck_sync;
    logic [1:0] sen_sync, sdi_sync;
    logic ref_edge, vco_edge, sck_rise, sck_fall;
    // registers
    logic [13:0] reference_divide_ratio;
    logic [18:0] integer_divide;
    logic [23:0] fraction_divide;
    logic [11:0] modulator_config;
    logic [11:0] lock_detect_config;
    logic [10:0] phase_detector_control;
    logic [6:0] output_pin_config;
    logic [1:0] lock_status;
    // serial port
    pll_ser_state_type ser_state;
    logic [4:0] bit_count;
    logic [29:0] shift_in;
    logic [23:0] shift_out;
    logic read_active, sdo_bit, wr_stb;
    logic [5:0] wr_addr;
    logic [23:0] wr_data, read_data;
    // dividers and phase detector
    logic ref_pulse, vco_pulse, frac_mode, frac_carry;
    logic [18:0] n_ratio;
    logic [23:0] frac_acc;
    logic up_state, dn_state;
    // lock detect
    logic win_open, first_ref, pair_done, pair_in, pair_reopen, lock_flag;
    logic [10:0] elapsed;
    logic [11:0] lock_count, lock_needed;
    pll_window_type window_len;

    // window length in clock cycles from the configuration word
    function automatic pll_window_type window_cycles(input logic [11:0] cfg);
        logic [10:0] span;
        span = (11'h001 << cfg[11:10]) << cfg[9:7];
        if (!cfg[`PLL_LD_WINSEL])
            return 11'(`PLL_ANALOG_WIN_CYC);
        if ((span >> 1) == 11'h000)
            return 11'h001;
        return span >> 1;
    endfunction : window_cycles

    // bounds the programmed n to the legal range for the mode
    function automatic logic [18:0] clamp_n(input logic [18:0] n, input logic frac);
        logic [18:0] low;
        low = frac ? `PLL_N_MIN_FRAC : `PLL_N_MIN_INT;
        if (n < low)
            return low;
        if (frac && n > `PLL_N_MAX_FRAC)
            return `PLL_N_MAX_FRAC;
        return n;
    endfunction : clamp_n

    // pins from outside are synchronised before any logic reads them
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ref_sync <= 3'h0;
            vco_sync <= 3'h0;
            sck_sync <= 3'h0;
            sen_sync <= 2'h0;
            sdi_sync <= 2'h0;
        end
        else
        begin
            ref_sync <= {ref_sync[1:0], ref_in};
            vco_sync <= {vco_sync[1:0], vco_in};
            sck_sync <= {sck_sync[1:0], serial_clock};
            sen_sync <= {sen_sync[0], serial_enable};
            sdi_sync <= {sdi_sync[0], serial_in};
        end
    end
    // edges are taken from the second and third stages only
    assign ref_edge = ref_sync[1] & ~ref_sync[2];
    assign vco_edge = vco_sync[1] & ~vco_sync[2];
    assign sck_rise = sck_sync[1] & ~sck_sync[2];
    assign sck_fall = ~sck_sync[1] & sck_sync[2];

    // serial frame: read flag, six address bits, 24 data bits
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ser_state <= pll_ser_idle;
            bit_count <= 5'h00;
            shift_in <= 30'h00000000;
            shift_out <= 24'h000000;
            read_active <= 1'b0;
            sdo_bit <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 6'h00;
            wr_data <= 24'h000000;
        end
        else
        begin
            wr_stb <= 1'b0;
            if (!sen_sync[1])
            begin
                // frame end; pin falls back to its select output
                ser_state <= pll_ser_idle;
                read_active <= 1'b0;
            end
            else
            begin
                case (ser_state)
                    pll_ser_idle:
                    begin
                        ser_state <= pll_ser_addr;
                        bit_count <= 5'h00;
                    end
                    pll_ser_addr:
                        if (sck_rise)
                        begin
                            shift_in <= {shift_in[28:0], sdi_sync[1]};
                            bit_count <= bit_count + 5'h01;
                            if (bit_count == `PLL_FRAME_ADDR_LAST)
                            begin
                                ser_state <= pll_ser_data;
                                wr_addr <= {shift_in[4:0], sdi_sync[1]};
                                read_active <= shift_in[5];
                                shift_out <= read_data;
                            end
                        end
                    pll_ser_data:
                    begin
                        if (sck_rise)
                        begin
                            shift_in <= {shift_in[28:0], sdi_sync[1]};
                            bit_count <= bit_count + 5'h01;
                            if (bit_count == `PLL_FRAME_LAST)
                            begin
                                ser_state <= pll_ser_wait;
                                wr_stb <= ~read_active;
                                wr_data <= {shift_in[22:0], sdi_sync[1]};
                            end
                        end
                        // read data leaves msb first on falling edges
                        if (sck_fall && read_active)
                        begin
                            sdo_bit <= shift_out[23];
                            shift_out <= {shift_out[22:0], 1'b0};
                        end
                    end
                    pll_ser_wait:
                        ser_state <= pll_ser_wait;
                    default:
                        ser_state <= pll_ser_idle;
                endcase
            end
        end
    end

    // register writes; read-only status ignores writes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reference_divide_ratio <= `PLL_RST_RDIV;
            integer_divide <= `PLL_RST_NINT;
            fraction_divide <= `PLL_RST_ZERO;
            modulator_config <= 12'h000;
            lock_detect_config <= 12'h000;
            phase_detector_control <= 11'h000;
            output_pin_config <= 7'h00;
        end
        else if (wr_stb)
        begin
            case (wr_addr)
                `PLL_ADDR_RDIV: reference_divide_ratio <= wr_data[13:0];
                `PLL_ADDR_NINT: integer_divide <= wr_data[18:0];
                `PLL_ADDR_NFRAC: fraction_divide <= wr_data;
                `PLL_ADDR_MODCFG: modulator_config <= wr_data[11:0];
                `PLL_ADDR_LDCFG: lock_detect_config <= wr_data[11:0];
                `PLL_ADDR_PDCTL: phase_detector_control <= wr_data[10:0];
                `PLL_ADDR_OUTCFG: output_pin_config <= wr_data[6:0];
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        read_data = 24'h000000;
        case ({shift_in[4:0], sdi_sync[1]})
            `PLL_ADDR_RDIV: read_data = {10'h000, reference_divide_ratio};
            `PLL_ADDR_NINT: read_data = {5'h00, integer_divide};
            `PLL_ADDR_NFRAC: read_data = fraction_divide;
            `PLL_ADDR_MODCFG: read_data = {12'h000, modulator_config};
            `PLL_ADDR_LDCFG: read_data = {12'h000, lock_detect_config};
            `PLL_ADDR_PDCTL: read_data = {13'h0000, phase_detector_control};
            `PLL_ADDR_OUTCFG: read_data = {17'h00000, output_pin_config};
            `PLL_ADDR_STATUS: read_data = {22'h000000, lock_status};
            default: read_data = 24'h000000;
        endcase
    end
    assign lock_status = {lock_flag, win_open};

    pll_div_counter #(.WIDTH(14)) ref_divider (
        .clock(clock),
        .rst(rst),
        .edge_in(ref_edge),
        .ratio(reference_divide_ratio),
        .pulse(ref_pulse)
    );

    assign frac_mode = modulator_config[`PLL_MOD_ENABLE] & ~modulator_config[`PLL_MOD_BYPASS];

    // fraction accumulator; its carry stretches one n cycle by one
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            frac_acc <= `PLL_RST_ZERO;
            frac_carry <= 1'b0;
            n_ratio <= `PLL_RST_NINT;
        end
        else
        begin
            if (vco_pulse && frac_mode)
                {frac_carry, frac_acc} <= {1'b0, frac_acc} + {1'b0, fraction_divide};
            else if (!frac_mode)
                frac_carry <= 1'b0;
            n_ratio <= clamp_n(integer_divide, frac_mode) + {18'h00000, frac_carry};
        end
    end

    // rf divider reuses the edge counter at 19 bits
    pll_div_counter #(.WIDTH(19)) rf_divider (
        .clock(clock),
        .rst(rst),
        .edge_in(vco_edge),
        .ratio(n_ratio),
        .pulse(vco_pulse)
    );

    // phase-frequency detector latches, each cleared when the other side's pulse arrives
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            up_state <= 1'b0;
            dn_state <= 1'b0;
        end
        else
        begin
            up_state <= (up_state | ref_pulse) & ~(dn_state | vco_pulse);
            dn_state <= (dn_state | vco_pulse) & ~(up_state | ref_pulse);
        end
    end

    // pump outputs; force bits override the enable masks
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pump_raise <= 1'b0;
            pump_lower <= 1'b0;
            pump_hiz <= 1'b1;
        end
        else
        begin
            pump_raise <= phase_detector_control[`PLL_PUMP_FORCE_RAISE]
                | (up_state & phase_detector_control[`PLL_DETECTOR_RAISE_ENABLE]);
            pump_lower <= phase_detector_control[`PLL_PUMP_FORCE_LOWER]
                | (dn_state & phase_detector_control[`PLL_DETECTOR_LOWER_ENABLE]);
            pump_hiz <= ~|{phase_detector_control[`PLL_PUMP_FORCE_LOWER:`PLL_PUMP_FORCE_RAISE],
                phase_detector_control[`PLL_DETECTOR_LOWER_ENABLE:`PLL_DETECTOR_RAISE_ENABLE]};
        end
    end

    // window from timer speed and divide
    assign window_len = window_cycles(lock_detect_config);
    // required hits, 16 to 2048
    // shift amount widened so that code 7 reaches 2048 instead of wrapping
    assign lock_needed = 12'h001 << ({1'b0, lock_detect_config[2:0]} + 4'(`PLL_LOCK_SHIFT));

    // pair completion: partner edge or window timeout closes the window
    always_comb
    begin
        pair_done = 1'b0;
        pair_in = 1'b0;
        pair_reopen = 1'b0;
        if (!win_open)
        begin
            // both edges in one cycle count as zero gap
            pair_done = ref_pulse & vco_pulse;
            pair_in = 1'b1;
            pair_reopen = ref_pulse ^ vco_pulse;
        end
        else if (first_ref ? vco_pulse : ref_pulse)
        begin
            pair_done = 1'b1;
            pair_in = elapsed < window_len;
        end
        // same edge twice: the partner never arrived, this edge starts afresh
        else if (first_ref ? ref_pulse : vco_pulse)
        begin
            pair_done = 1'b1;
            pair_reopen = 1'b1;
        end
        // window ran out unanswered: a miss, and the late partner opens its own
        // window, so pairing settles on the nearer edge whatever the start phase
        else if (elapsed >= window_len)
        begin
            pair_done = 1'b1;
        end
    end

    // window timer
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            win_open <= 1'b0;
            first_ref <= 1'b0;
            elapsed <= 11'h000;
        end
        else if (!lock_detect_config[`PLL_LD_ENABLE])
        begin
            win_open <= 1'b0;
            elapsed <= 11'h000;
        end
        else if (pair_reopen)
        begin
            win_open <= 1'b1;
            first_ref <= ref_pulse;
            elapsed <= 11'h001;
        end
        else if (pair_done)
        begin
            win_open <= 1'b0;
        end
        else if (win_open && elapsed != 11'h7FF)
        begin
            elapsed <= elapsed + 11'h001;
        end
    end

    // consecutive hit counter and lock flag
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lock_count <= 12'h000;
            lock_flag <= 1'b0;
        end
        else if (!lock_detect_config[`PLL_LD_ENABLE])
        begin
            lock_count <= 12'h000;
            lock_flag <= 1'b0;
        end
        else if (pair_done)
        begin
            if (!pair_in)
            begin
                lock_count <= 12'h000;
                lock_flag <= 1'b0;
            end
            else if (lock_count + 12'h001 >= lock_needed)
            begin
                lock_count <= lock_needed;
                lock_flag <= 1'b1;
            end
            else
            begin
                lock_count <= lock_count + 12'h001;
            end
        end
    end

    // shared pin: serial data during reads unless told to keep lock
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            lock_or_serial_out_pin <= 1'b0;
        else if (read_active && !output_pin_config[`PLL_OUT_KEEP])
            lock_or_serial_out_pin <= sdo_bit;
        else
            lock_or_serial_out_pin <= (output_pin_config[4:0] == `PLL_OUT_SEL_LOCK) & lock_flag;
    end

    property p_up_mask;
        @(posedge clock) disable iff (rst)
        !phase_detector_control[5] && !phase_detector_control[9] |=> !pump_raise;
    endproperty
    a_up_mask: assert property (p_up_mask) else $error("pump up not masked");
    property p_dn_mask;
        @(posedge clock) disable iff (rst)
        !phase_detector_control[6] && !phase_detector_control[10] |=> !pump_lower;
    endproperty
    a_dn_mask: assert property (p_dn_mask) else $error("pump down not masked");
    property p_hiz;
        @(posedge clock) disable iff (rst)
        phase_detector_control[10:9] == 2'h0 && phase_detector_control[6:5] == 2'h0
        |=> pump_hiz && !pump_raise && !pump_lower;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pump not tri-stated");
    property p_force;
        @(posedge clock) disable iff (rst)
        phase_detector_control[9] ##1 phase_detector_control[9] |-> pump_raise;
    endproperty
    a_force: assert property (p_force) else $error("force up ignored");
    property p_disabled;
        @(posedge clock) disable iff (rst)
        !lock_detect_config[3] |=> !lock_flag && lock_count == 12'h000 && !win_open;
    endproperty
    a_disabled: assert property (p_disabled) else $error("detector active while off");
    property p_miss;
        @(posedge clock) disable iff (rst)
        pair_done && !pair_in |=> !lock_flag && lock_count == 12'h000;
    endproperty
    a_miss: assert property (p_miss) else $error("miss did not clear lock");
    property p_rise;
        @(posedge clock) disable iff (rst)
        $rose(lock_flag) |-> $past(pair_done) && $past(lock_count) + 12'h001 >= $past(lock_needed);
    endproperty
    a_rise: assert property (p_rise) else $error("lock set early");
    property p_pin;
        @(posedge clock) disable iff (rst)
        !read_active && output_pin_config[4:0] == 5'h01 |=> lock_or_serial_out_pin == $past(lock_flag);
    endproperty
    a_pin: assert property (p_pin) else $error("pin not showing lock");
endmodule : pll_lock_detect

// [pll_edge_model.sv]
// edge source standing in for the reference oscillator and the vco prescaler
// assumes a 40 MHz clock; the enables are changed by the bench between tests
`timescale 1ns/1ps
module pll_edge_model (
    input wire logic clock,
    input wire logic ref_on,
    input wire logic vco_on,
    output logic ref_in = 1'b0,
    output logic vco_in = 1'b0
);
    // ref period of 96 clocks is exactly 16 vco periods of 6 clocks
    logic [6:0] ref_cnt = 7'h00;
    logic [2:0] vco_cnt = 3'h0;
    // pulses three clocks wide keep rising edges apart; a stopped source idles low
    always @(negedge clock)
    begin
        ref_cnt <= (ref_cnt == 7'h5F) ? 7'h00 : ref_cnt + 7'h01;
        vco_cnt <= (vco_cnt == 3'h5) ? 3'h0 : vco_cnt + 3'h1;
        ref_in <= ref_on && (ref_cnt < 7'h03);
        vco_in <= vco_on && (vco_cnt < 3'h3);
    end
endmodule : pll_edge_model

// [pll_lock_detect_bench.sv]
// self-checking bench for the dividers, pump gating and lock detect
// assumes the edge model on the reference and rf inputs and a host driven here on the serial pins
`timescale 1ns/1ps
`include "pll_consts.svh"
module pll_lock_detect_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic serial_clock = 1'b0;
    logic serial_enable = 1'b0;
    logic serial_in = 1'b0;
    logic ref_on = 1'b0;
    logic vco_on = 1'b0;
    logic ref_in, vco_in, pump_raise, pump_lower, pump_hiz, pin;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [23:0] rd_val;
    // register rows: address, word written, word read back (narrow fields drop high bits)
    // the pin row keeps bit 6 clear, else later reads would never reach the pin;
    // the modulator row keeps bypass set so the rf divider stays in integer mode
    logic [53:0] rows [0:7] = '{{6'h02, 24'hFFFFFF, 24'h003FFF},
        {6'h07, 24'hFFFFFF, 24'h000FFF}, {6'h0B, 24'hFFFFFF, 24'h0007FF},
        {6'h0F, 24'hFFFFBF, 24'h00003F}, {6'h03, 24'hFFFFFF, 24'h07FFFF},
        {6'h04, 24'hFFFFFF, 24'hFFFFFF}, {6'h06, 24'hFFFFFF, 24'h000FFF},
        {6'h15, 24'hFFFFFF, 24'h000000}};
    // pump rows: ref on, vco on, pump control word, expected raise/lower/hiz
    logic [15:0] pumps [0:6] = '{{1'h1, 1'h0, 11'h020, 3'h4}, {1'h1, 1'h0, 11'h040, 3'h0},
        {1'h0, 1'h1, 11'h020, 3'h0}, {1'h0, 1'h1, 11'h040, 3'h2},
        {1'h0, 1'h1, 11'h000, 3'h1}, {1'h0, 1'h1, 11'h200, 3'h4},
        {1'h0, 1'h1, 11'h400, 3'h2}};
    // 25 ns period
    always #12.5 clock = ~clock;
    pll_edge_model model (.clock(clock), .ref_on(ref_on), .vco_on(vco_on),
        .ref_in(ref_in), .vco_in(vco_in));
    pll_lock_detect dut (.clock(clock), .rst(rst), .ref_in(ref_in), .vco_in(vco_in),
        .serial_clock(serial_clock), .serial_enable(serial_enable), .serial_in(serial_in),
        .pump_raise(pump_raise), .pump_lower(pump_lower), .pump_hiz(pump_hiz),
        .lock_or_serial_out_pin(pin));
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one 31-bit frame; serial clock phases of 8 clocks low and 4 high sit above the three-clock minimum,
    // and a read samples the pin late in each low phase, after the data has settled
    task automatic frame(input logic rd, input logic [5:0] a, input logic [23:0] d);
        logic [30:0] fr;
        fr = {rd, a, d};
        rd_val = 24'h000000;
        serial_enable = 1'b1;
        cyc(4);
        for (int k = 0; k < 31; k++)
        begin
            serial_in = fr[30-k];
            serial_clock = 1'b0;
            cyc(8);
            if (k > 6)
                rd_val[30-k] = pin;
            serial_clock = 1'b1;
            cyc(4);
        end
        serial_clock = 1'b0;
        cyc(2);
        serial_enable = 1'b0;
        cyc(8);
    endtask : frame
    task automatic wait_lock;
        for (int i = 0; i < 1000 && pin !== 1'b1; i++)
            cyc(1);
    endtask : wait_lock
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // watchdog: the sequence needs roughly 20000 clocks
    initial
    begin
        cyc(40000);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        cyc(4);
        rst = 1'b0;
        cyc(2);
        check(24'({pump_raise, pump_lower, pump_hiz, pin}), 24'h000002);
        frame(1'b1, `PLL_ADDR_RDIV, 24'h000000);
        check(rd_val, 24'h000001);
        frame(1'b1, `PLL_ADDR_NINT, 24'h000000);
        check(rd_val, 24'h000014);
        frame(1'b1, `PLL_ADDR_STATUS, 24'h000000);
        check(rd_val, 24'h000000);
        for (int i = 0; i < 8; i++)
        begin
            frame(1'b0, rows[i][53:48], rows[i][47:24]);
            frame(1'b1, rows[i][53:48], 24'h000000);
            check(rd_val, rows[i][23:0]);
        end
        // integer mode, divide ratio 16 so divided vco matches the 96 clock reference
        frame(1'b0, `PLL_ADDR_RDIV, 24'h000001);
        frame(1'b0, `PLL_ADDR_NINT, 24'h000010);
        frame(1'b0, `PLL_ADDR_LDCFG, 24'h000000);
        // one source alone holds the detector in one direction
        for (int i = 0; i < 7; i++)
        begin
            ref_on = pumps[i][15];
            vco_on = pumps[i][14];
            frame(1'b0, `PLL_ADDR_PDCTL, 24'(pumps[i][13:3]));
            cyc(300);
            check(24'({pump_raise, pump_lower, pump_hiz}), 24'(pumps[i][2:0]));
        end
        ref_on = 1'b1;
        frame(1'b0, `PLL_ADDR_PDCTL, 24'h000060);
        frame(1'b0, `PLL_ADDR_OUTCFG, 24'(`PLL_OUT_SEL_LOCK));
        // digital window only: the analog one shot is never selected here
        // 64 cycle window: above the 48 cycle worst gap, below the 96 cycle period
        frame(1'b0, `PLL_ADDR_LDCFG, 24'h0003C8);
        cyc(1300);
        check(24'(pin), 24'h000000);
        wait_lock();
        check(24'(pin), 24'h000001);
        frame(1'b1, `PLL_ADDR_STATUS, 24'h000000);
        check(rd_val & 24'h000002, 24'h000002);
        check(24'(pin), 24'h000001);
        // a reference edge left unanswered until the window runs out is a miss
        vco_on = 1'b0;
        cyc(300);
        check(24'(pin), 24'h000000);
        vco_on = 1'b1;
        cyc(1200);
        check(24'(pin), 24'h000000);
        wait_lock();
        check(24'(pin), 24'h000001);
        frame(1'b0, `PLL_ADDR_LDCFG, 24'h0003C0);
        check(24'(pin), 24'h000000);
        cyc(2000);
        check(24'(pin), 24'h000000);
        report_and_stop();
    end
endmodule : pll_lock_detect_bench
